// ===== dll_mode_ctrl.sv
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps
// Overview of operation
// - DLL off: only CL 6, CWL 6 accepted
// - MR1 bit 0 set disables DLL, clear enables
// - DLL off: strobe starts AL+CL-1 cycles
// - Strobe follows clock by 1 to 10 ns; here it toggles two mclk cycles after the synchronised edge
// - Strobe delay may exceed one clock period
// - Next command after larger mode delay
// - Clock ignored after entry hold in self refresh
module dll_mode_ctrl
  import dll_mode_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Memory link pins
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] addr,
  // Read strobe
  output logic             dqs_o,
  output logic             dqs_oe
);
  logic [22:0] pin_s;
  logic        ck_rise, ck_fall;
  logic [31:0] ctrl_q;
  logic [13:0] mr0_q, mr1_q, mr2_q;
  pwr_e        pwr_q;
  logic [3:0]  hold_cnt_q;
  logic [4:0]  busy_cnt_q;
  logic [9:0]  lock_cnt_q;
  logic        lat_err_q, refused_q;
  logic [5:0]  lat_cnt_q;
  logic        rd_wait_q, burst_q;
  logic [3:0]  edge_cnt_q;
  logic        edge_dly_q;
  logic        cke_prev_q;

  pin_sync #(.W(23)) u_sync (
    .mclk  (mclk),
    .rstn  (rstn),
    .pins  ({addr, ba, we_n, cas_n, ras_n, cs_n, cke, ck}),
    .sync  (pin_s),
    .rise0 (ck_rise),
    .fall0 (ck_fall)
  );

  wire        s_cke  = pin_s[1];
  wire [3:0]  s_cmd  = pin_s[5:2];   // {we_n, cas_n, ras_n, cs_n}
  wire [2:0]  s_ba   = pin_s[8:6];
  wire [13:0] s_addr = pin_s[22:9];
  wire        dll_off = mr1_q[MR1_DLL_OFF_BIT];

  function automatic logic [5:0] cl_of(input logic [13:0] mr0);
    cl_of = CL_BASE + {3'b000, mr0[MR0_CL_LSB +: 3]};
  endfunction : cl_of

  function automatic logic [5:0] cwl_of(input logic [13:0] mr2);
    cwl_of = CWL_BASE + {3'b000, mr2[MR2_CWL_LSB +: 3]};
  endfunction : cwl_of

  // Clock edges are discarded in every state but active, including the self refresh entry hold
  wire ck_live = ck_rise && (pwr_q == ST_ACTIVE);
  wire en      = ctrl_q[CTRL_EN_BIT];
  wire is_mrs  = ck_live && s_cke && en && (s_cmd == 4'b0000);
  wire is_sre  = ck_live && cke_prev_q && !s_cke && en && (s_cmd == 4'b1000);
  wire is_rd   = ck_live && s_cke && en && (s_cmd == 4'b1010);
  wire is_cmd  = ck_live && s_cke && en && (s_cmd[0] == 1'b0);
  wire busy    = busy_cnt_q != 5'h00;
  wire take    = is_cmd && !busy;
  wire bad_lat = is_mrs && !busy && dll_off &&
                 (((s_ba == 3'h0) && (cl_of(s_addr) != DLL_OFF_CL)) ||
                  ((s_ba == 3'h2) && (cwl_of(s_addr) != DLL_OFF_CWL)));

  // Additive latency from MR1 plus CAS latency, one less with the DLL off
  wire [5:0] cl_eff = dll_off ? DLL_OFF_CL : cl_of(mr0_q);
  wire [5:0] al_val = (mr1_q[MR1_AL_LSB +: 2] == 2'h1) ? cl_eff - 6'h01 :
                      (mr1_q[MR1_AL_LSB +: 2] == 2'h2) ? cl_eff - 6'h02 : 6'h00;
  wire [5:0] rd_lat = al_val + cl_eff - {5'h00, dll_off};

  // Mode registers; out-of-range latencies are dropped while the DLL is off
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mr0_q <= MR_RST;
      mr1_q <= MR_RST;
      mr2_q <= MR_RST;
    end else if (is_mrs && !busy && !bad_lat) begin
      case (s_ba)
        3'h0:    mr0_q <= s_addr;
        3'h1:    mr1_q <= s_addr;
        3'h2:    mr2_q <= s_addr;
        default: ;
      endcase
    end
  end

  // Commands after a mode write wait out the larger mode delay
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) busy_cnt_q <= 5'h00;
    else if (is_mrs && !busy) busy_cnt_q <= READY_CK;
    else if (ck_live && busy) busy_cnt_q <= busy_cnt_q - 5'h01;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) lock_cnt_q <= 10'h000;
    else if (is_mrs && !busy && s_ba == 3'h0 && s_addr[MR0_DLL_RST_BIT] && !dll_off)
      lock_cnt_q <= DLL_LOCK_CK;
    else if (ck_live && lock_cnt_q != 10'h000) lock_cnt_q <= lock_cnt_q - 10'h001;
  end

  // Power state; the clock is only watched again when CKE rises
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pwr_q      <= ST_ACTIVE;
      hold_cnt_q <= 4'h0;
      cke_prev_q <= 1'b1;
    end else begin
      if (ck_rise) cke_prev_q <= s_cke;
      case (pwr_q)
        ST_ACTIVE: begin
          if (is_sre) begin
            pwr_q      <= ST_SREF;
            hold_cnt_q <= 4'(SR_HOLD_CYC);
          end else if (ck_live && cke_prev_q && !s_cke) pwr_q <= ST_PDOWN;
        end
        ST_SREF: begin
          if (s_cke) pwr_q <= ST_ACTIVE;
          else if (hold_cnt_q <= 4'h1) pwr_q <= ST_CK_IGN;
          else hold_cnt_q <= hold_cnt_q - 4'h1;
        end
        ST_CK_IGN: if (s_cke) pwr_q <= ST_ACTIVE;
        ST_PDOWN:  if (s_cke) pwr_q <= ST_ACTIVE;
        default:   pwr_q <= ST_ACTIVE;
      endcase
      if (pwr_q != ST_ACTIVE && s_cke) cke_prev_q <= 1'b1;
    end
  end

  // Read latency counted in rising clock edges; one read in flight, later reads are not queued
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_wait_q <= 1'b0;
      lat_cnt_q <= 6'h00;
    end else if (take && is_rd && !rd_wait_q && !burst_q) begin
      rd_wait_q <= 1'b1;
      lat_cnt_q <= rd_lat;
    end else if (rd_wait_q && ck_rise) begin
      if (lat_cnt_q <= 6'h01) rd_wait_q <= 1'b0;
      lat_cnt_q <= lat_cnt_q - 6'h01;
    end
  end

  // The arming rise launches the first toggle itself, so the window opens at that edge
  wire strobe_arm = rd_wait_q && ck_rise && lat_cnt_q <= 6'h01;

  // Strobe toggles on both clock edges, two mclk cycles after each edge is seen
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      burst_q    <= 1'b0;
      edge_cnt_q <= 4'h0;
      edge_dly_q <= 1'b0;
      dqs_o      <= 1'b0;
      dqs_oe     <= 1'b0;
    end else begin
      edge_dly_q <= (ck_rise || ck_fall) && (burst_q || strobe_arm);
      if (strobe_arm) begin
        burst_q    <= 1'b1;
        edge_cnt_q <= BURST_EDGES;
      end else if (edge_dly_q) begin
        dqs_oe     <= 1'b1;
        dqs_o      <= ~dqs_o;
        edge_cnt_q <= edge_cnt_q - 4'h1;
        if (edge_cnt_q == 4'h1) burst_q <= 1'b0;
      end else if (!burst_q) begin
        dqs_oe <= 1'b0;
        dqs_o  <= 1'b0;
      end
    end
  end

  // Sticky error flags: a new event wins over the software clear
  // Writes land at the edge where the master samples ack, as classic Wishbone expects
  wire ctrl_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == CTRL_OFS &&
                 wb_sel_i[0];
  wire clr     = ctrl_wr && wb_dat_i[CTRL_CLR_BIT];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lat_err_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      lat_err_q <= bad_lat || (lat_err_q && !clr);
      refused_q <= (is_cmd && busy) || (refused_q && !clr);
    end
  end

  // Wishbone slave: answers one cycle after the request
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_q   <= CTRL_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (ctrl_wr)
        ctrl_q[CTRL_EN_BIT] <= wb_dat_i[CTRL_EN_BIT];
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          CTRL_OFS: wb_dat_o <= ctrl_q;
          STAT_OFS: wb_dat_o <= {24'h000000, refused_q, lat_err_q, busy,
                                 lock_cnt_q == 10'h000, pwr_q == ST_PDOWN,
                                 pwr_q == ST_CK_IGN, pwr_q != ST_ACTIVE &&
                                 pwr_q != ST_PDOWN, dll_off};
          MR0_OFS:  wb_dat_o <= {18'h00000, mr0_q};
          MR1_OFS:  wb_dat_o <= {18'h00000, mr1_q};
          MR2_OFS:  wb_dat_o <= {18'h00000, mr2_q};
          default:  wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_latency_lock: assert property (@(posedge mclk) disable iff (!rstn)
    dll_off |-> (cl_of(mr0_q) == DLL_OFF_CL || $past(dll_off) == 1'b0 ||
                 $stable(mr0_q))) else $error("latency changed while dll off");
  a_dll_off_set: assert property (@(posedge mclk) disable iff (!rstn)
    (is_mrs && !busy && s_ba == 3'h1 && !bad_lat) |=> dll_off == $past(s_addr[0]))
    else $error("dll off bit not taken");
  a_read_latency: assert property (@(posedge mclk) disable iff (!rstn)
    (take && is_rd && !rd_wait_q && !burst_q) |=>
      lat_cnt_q == $past(al_val) + $past(cl_eff) - {5'h00, $past(dll_off)})
    else $error("read latency wrong");
  // Edge seen, then the delay flop, then the toggle: two mclk cycles in all
  a_strobe_delay: assert property (@(posedge mclk) disable iff (!rstn)
    ((ck_rise || ck_fall) && (burst_q || strobe_arm)) |-> ##2 ($changed(dqs_o) && dqs_oe))
    else $error("strobe delay out of window");
  a_ck_ignored: assert property (@(posedge mclk) disable iff (!rstn)
    (pwr_q == ST_CK_IGN) |=> ($stable(busy_cnt_q) && $stable(lock_cnt_q) && $stable(mr1_q)))
    else $error("clock used in self refresh");
  a_sr_hold: assert property (@(posedge mclk) disable iff (!rstn)
    is_sre |=> (pwr_q == ST_SREF) ##1 (pwr_q == ST_CK_IGN || $past(s_cke)))
    else $error("entry hold wrong");
  a_ready_delay: assert property (@(posedge mclk) disable iff (!rstn)
    (is_mrs && !busy) |=> busy_cnt_q == READY_CK) else $error("mode delay wrong");
  a_burst_len: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(burst_q) |-> edge_cnt_q == BURST_EDGES) else $error("burst length wrong");

  c_read_dll_off: cover property (@(posedge mclk) disable iff (!rstn) is_rd && dll_off);
  c_sr_ignore:    cover property (@(posedge mclk) disable iff (!rstn) pwr_q == ST_CK_IGN);
  c_bad_lat:      cover property (@(posedge mclk) disable iff (!rstn) bad_lat);
  c_pdown:        cover property (@(posedge mclk) disable iff (!rstn) pwr_q == ST_PDOWN);
endmodule : dll_mode_ctrl

// ===== dll_mode_pkg.sv
package dll_mode_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STAT_OFS        = 8'h04;
  localparam logic [7:0]  MR0_OFS         = 8'h08;
  localparam logic [7:0]  MR1_OFS         = 8'h0c;
  localparam logic [7:0]  MR2_OFS         = 8'h10;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0001;
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_CLR_BIT    = 1;
  // Status bit positions
  localparam int          ST_DLL_OFF_BIT  = 0;
  localparam int          ST_SREF_BIT     = 1;
  localparam int          ST_CKIGN_BIT    = 2;
  localparam int          ST_PDOWN_BIT    = 3;
  localparam int          ST_LOCKED_BIT   = 4;
  localparam int          ST_BUSY_BIT     = 5;
  localparam int          ST_LATERR_BIT   = 6;
  localparam int          ST_REFUSED_BIT  = 7;
  // Mode register fields
  localparam int          MR1_DLL_OFF_BIT = 0;
  localparam int          MR1_AL_LSB      = 3;
  localparam int          MR0_DLL_RST_BIT = 8;
  localparam int          MR0_CL_LSB      = 4;
  localparam int          MR2_CWL_LSB     = 3;
  localparam logic [13:0] MR_RST          = 14'h0000;
  localparam logic [5:0]  CL_BASE         = 6'h04;
  localparam logic [5:0]  CWL_BASE        = 6'h05;
  localparam logic [5:0]  DLL_OFF_CL      = 6'h06;
  localparam logic [5:0]  DLL_OFF_CWL     = 6'h06;
  // Timing
  localparam int          MCLK_PS         = 10000;
  localparam int          DQSCK_MIN_PS    = 1000;
  localparam int          DQSCK_MAX_PS    = 10000;
  localparam int          DQSCK_MIN_CYC   = (DQSCK_MIN_PS + MCLK_PS - 1) / MCLK_PS;
  localparam int          DQSCK_MAX_CYC   = DQSCK_MAX_PS / MCLK_PS;
  localparam int          SR_HOLD_NS      = 10;
  localparam int          SR_HOLD_CYC     = (SR_HOLD_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam logic [4:0]  MRD_CK          = 5'h04;
  localparam logic [4:0]  MOD_CK          = 5'h0c;
  localparam logic [4:0]  READY_CK        = (MRD_CK > MOD_CK) ? MRD_CK : MOD_CK;
  localparam logic [9:0]  DLL_LOCK_CK     = 10'h200;
  localparam logic [3:0]  BURST_EDGES     = 4'h8;

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'b0001,
    ST_SREF   = 4'b0010,
    ST_CK_IGN = 4'b0100,
    ST_PDOWN  = 4'b1000
  } pwr_e;
endpackage : dll_mode_pkg

// ===== mem_ctrl_model.sv
`timescale 1ns/100ps
module mem_ctrl_model
  import dll_mode_pkg::*;
#(
  parameter int HALF_NS = 80
) (
  // Memory clock and command pins
  output logic        ck,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [13:0] addr
);
  logic run_q;

  initial begin
    ck = 1'b0;
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 3'h0;
    addr = 14'h0;
    run_q = 1'b1;
  end

  // Clock halts only in self refresh, where its level is a don't-care
  always begin
    #HALF_NS;
    if (run_q) begin
      // Period never moves, so it stays inside the speed grade's limits
      ck = ~ck;
    end
  end

  task automatic wait_ck(input int n);
    repeat (n) @(posedge ck);
  endtask : wait_ck

  // Pins move on the falling edge so they are stable around the rising edge
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
                       input logic ke);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    cke <= ke;
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    // Deselected address is a don't-care, so it must not echo the last value
    ba <= ~b;
    addr <= ~a;
  endtask : issue

  task automatic mrs(input logic [2:0] b, input logic [13:0] a);
    issue(4'h0, b, a, 1'b1);
    wait_ck(int'(READY_CK) + 2);
  endtask : mrs

  task automatic rd();
    issue(4'h5, 3'h0, 14'h0, 1'b1);
  endtask : rd

  task automatic sr_enter();
    issue(4'h1, 3'h0, 14'h0, 1'b0);
    wait_ck(2);
    run_q = 1'b0;
  endtask : sr_enter

  task automatic sr_exit();
    run_q = 1'b1;
    wait_ck(5);
    @(negedge ck);
    cke <= 1'b1;
    wait_ck(int'(READY_CK) + 2);
  endtask : sr_exit

  task automatic pd_step(input logic ke);
    @(negedge ck);
    cke <= ke;
    wait_ck(4);
  endtask : pd_step
endmodule : mem_ctrl_model

// ===== pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // Pins and synchronised copies
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] sync,
  output logic              rise0,
  output logic              fall0
);
  logic [W-1:0] meta_q;
  logic         prev_q;

  // Bit 0 carries the link clock; edge detection looks only at the second stage
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync   <= '0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pins;
      sync   <= meta_q;
      prev_q <= sync[0];
    end
  end

  assign rise0 = sync[0] & ~prev_q;
  assign fall0 = ~sync[0] & prev_q;
endmodule : pin_sync

// ===== tb.sv
`timescale 1ns/100ps
module tb
  import dll_mode_pkg::*;
;
  logic        mclk, rstn, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rv;
  logic        ck, cke, cs_n, ras_n, cas_n, we_n, dqs_o, dqs_oe;
  logic [2:0]  ba;
  logic [13:0] addr;
  int          err_total, n_checks, cyc_n, rise_n, tog_n;

  dll_mode_ctrl u_dll_mode_ctrl (
    .mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .dqs_o(dqs_o), .dqs_oe(dqs_oe)
  );
  mem_ctrl_model u_mem_ctrl_model (
    .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr)
  );

  always #5 mclk = ~mclk;
  always @(posedge ck) rise_n++;
  always @(dqs_o) tog_n++;
  // Whole run is about 12000 cycles, so this leaves ample slack
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(nm, rv, e);
  endtask : rd_chk

  task automatic st_chk(input string nm, input int b, input logic e);
    xfer(1'b0, STAT_OFS, 32'h0);
    check(nm, {31'h0, rv[b]}, {31'h0, e});
  endtask : st_chk

  task automatic strobe(input int rises);
    int b;
    int t;
    t = tog_n;
    u_mem_ctrl_model.rd();
    b = rise_n;
    repeat (400) if (dqs_o !== 1'b1) @(posedge mclk);
    check("strobe start", rise_n - b, rises);
    check("strobe oe on", {31'h0, dqs_oe}, 32'h1);
    repeat (400) if (dqs_oe !== 1'b0) @(posedge mclk);
    check("strobe edges", tog_n - t, 8);
    check("strobe rest", {31'h0, dqs_o}, 32'h0);
    check("strobe oe off", {31'h0, dqs_oe}, 32'h0);
  endtask : strobe

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hf;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    rd_chk("ctrl", CTRL_OFS, CTRL_RST);
    rd_chk("mr1 rst", MR1_OFS, 32'h0);
    xfer(1'b1, 8'h40, 32'hffff_ffff);
    rd_chk("unmapped", 8'h40, 32'h0);
    // Decoding off: a mode write must not land
    xfer(1'b1, CTRL_OFS, 32'h0);
    u_mem_ctrl_model.mrs(3'h1, 14'h0001);
    rd_chk("mr1 gated", MR1_OFS, 32'h0);
    xfer(1'b1, CTRL_OFS, 32'h1);
    $display("test registers done");
    // Early command after a mode write is refused and reads nothing
    tog_n = 0;
    u_mem_ctrl_model.issue(4'h0, 3'h1, 14'h0001, 1'b1);
    u_mem_ctrl_model.wait_ck(2);
    st_chk("busy", ST_BUSY_BIT, 1'b1);
    u_mem_ctrl_model.rd();
    u_mem_ctrl_model.wait_ck(16);
    check("refused rd", tog_n, 0);
    st_chk("busy end", ST_BUSY_BIT, 1'b0);
    st_chk("refused", ST_REFUSED_BIT, 1'b1);
    st_chk("dll off", ST_DLL_OFF_BIT, 1'b1);
    rd_chk("mr1", MR1_OFS, 32'h1);
    xfer(1'b1, CTRL_OFS, 32'h3);
    st_chk("refused clr", ST_REFUSED_BIT, 1'b0);
    $display("test dll off entry done");
    u_mem_ctrl_model.mrs(3'h0, 14'h0010);
    st_chk("cl 5", ST_LATERR_BIT, 1'b1);
    rd_chk("mr0 kept", MR0_OFS, 32'h0);
    u_mem_ctrl_model.mrs(3'h0, 14'h0020);
    rd_chk("mr0 cl 6", MR0_OFS, 32'h20);
    xfer(1'b1, CTRL_OFS, 32'h3);
    u_mem_ctrl_model.mrs(3'h2, 14'h0010);
    st_chk("cwl 7", ST_LATERR_BIT, 1'b1);
    rd_chk("mr2 kept", MR2_OFS, 32'h0);
    u_mem_ctrl_model.mrs(3'h2, 14'h0008);
    rd_chk("mr2 cwl 6", MR2_OFS, 32'h8);
    $display("test latencies done");
    strobe(5);
    // Additive latency CL-1 on top: 5 + 6 - 1 rises with the DLL off
    u_mem_ctrl_model.mrs(3'h1, 14'h0009);
    strobe(10);
    u_mem_ctrl_model.mrs(3'h1, 14'h0001);
    $display("test dll off read done");
    u_mem_ctrl_model.sr_enter();
    st_chk("sref", ST_SREF_BIT, 1'b1);
    st_chk("ck ignored", ST_CKIGN_BIT, 1'b1);
    u_mem_ctrl_model.sr_exit();
    st_chk("sref exit", ST_SREF_BIT, 1'b0);
    $display("test self refresh done");
    u_mem_ctrl_model.mrs(3'h1, 14'h0000);
    st_chk("dll on", ST_DLL_OFF_BIT, 1'b0);
    u_mem_ctrl_model.mrs(3'h0, 14'h0120);
    st_chk("relock", ST_LOCKED_BIT, 1'b0);
    u_mem_ctrl_model.wait_ck(int'(DLL_LOCK_CK) + 4);
    st_chk("locked", ST_LOCKED_BIT, 1'b1);
    strobe(6);
    $display("test dll on done");
    u_mem_ctrl_model.pd_step(1'b0);
    st_chk("pdown", ST_PDOWN_BIT, 1'b1);
    u_mem_ctrl_model.pd_step(1'b1);
    st_chk("pdown exit", ST_PDOWN_BIT, 1'b0);
    u_mem_ctrl_model.mrs(3'h0, 14'h0120);
    st_chk("pd relock", ST_LOCKED_BIT, 1'b0);
    $display("test power down done");
    stop_test();
  end
endmodule : tb
